// *** logic/smr_supply_monitor.sv ***
`timescale 1ns/1ps
// What this block does
// - reference source on while any consumer enabled
// - high enable bit starts high reference
// - low enable bit starts low reference
// - pin output only while its reference enabled
// - detector enable bit powers the detector
// - supply at/below trip sets flag, interrupt
// - supply-drop interrupt wakes device from sleep
// - four-bit trip select picks the level
// - flag clear refused while supply still low
// - detector flag setting blocked until reference stable
// - read-only stable bit shows reference stability
// - trip code 1111 selects external trip input
module smr_supply_monitor
    import smr_pkg::*;
#(
    parameter int REF_START_CYCLES = SMR_REF_START_CYC,
    parameter int AMP_START_CYCLES = SMR_AMP_START_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic supply_below_internal,
    input wire logic supply_below_external,
    input wire logic brownout_strap,
    output logic ref_source_on,
    output logic [3:0] trip_select,
    output logic external_trip_input_sel,
    output logic detector_on,
    output logic high_internal_ref_on,
    output logic low_internal_ref_on,
    output logic high_internal_ref_ready,
    output logic low_internal_ref_ready,
    output logic high_ref_pin_drive,
    output logic low_ref_pin_drive,
    output logic supply_drop_irq,
    output logic wake_request
);
    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef struct packed {
        logic supply_drop_flag;
        logic supply_drop_irq_enable;
        logic high_ref_enable;
        logic low_ref_enable;
        logic high_ref_pin_out;
        logic low_ref_pin_out;
        logic detector_enable;
        logic [3:0] trip_select;
        logic brownout_enable;
        logic strap_taken;
        logic [7:0] rdata;
    } smr_state_t;

    smr_state_t st_q;
    smr_state_t st_d;
    smr_bus_req_t req;
    logic src_powered;
    logic src_stable;
    logic below_trip;
    logic power_req;
    logic high_amp_ready;
    logic low_amp_ready;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
                   rd: reg_rd};

    // ----------------------------------------------------------
    // reference source and gain amplifier settling
    // ----------------------------------------------------------
    // any consumer keeps the shared source powered
    assign power_req = st_q.brownout_enable | st_q.detector_enable
                     | st_q.high_ref_enable | st_q.low_ref_enable;

    smr_ref_source #(
        .START_CYCLES(REF_START_CYCLES)
    ) u_source (
        .sys_clk(sys_clk),
        .rst(rst),
        .power_req(power_req),
        .powered(src_powered),
        .stable(src_stable)
    );

    smr_settle_timer #(
        .CYCLES(AMP_START_CYCLES)
    ) u_high_amp (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(st_q.high_ref_enable & src_stable),
        .ready(high_amp_ready)
    );

    smr_settle_timer #(
        .CYCLES(AMP_START_CYCLES)
    ) u_low_amp (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(st_q.low_ref_enable & src_stable),
        .ready(low_amp_ready)
    );

    // ----------------------------------------------------------
    // trip comparison
    // ----------------------------------------------------------
    // code 1111 takes the external pin comparator
    assign below_trip = (st_q.trip_select == SMR_TRIP_EXTERNAL)
                      ? supply_below_external
                      : supply_below_internal;

    // ----------------------------------------------------------
    // next state: registers, flag, read data
    // ----------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.rdata = 8'h00;
        // brownout enable follows a strap caught after reset release
        if (!st_q.strap_taken)
        begin
            st_d.strap_taken = 1'b1;
            st_d.brownout_enable = brownout_strap;
        end
        // register writes
        if (req.wr)
        begin
            case (req.addr)
                SMR_OFF_PERIPH_FLAGS_TWO:
                begin
                    // clear only when supply is back above trip
                    if (!req.wdata[SMR_BIT_DROP_FLAG] && !below_trip)
                        st_d.supply_drop_flag = 1'b0;
                    else if (req.wdata[SMR_BIT_DROP_FLAG])
                        st_d.supply_drop_flag = 1'b1;
                end
                SMR_OFF_PERIPH_ENABLES_TWO:
                    st_d.supply_drop_irq_enable =
                        req.wdata[SMR_BIT_DROP_IRQ_EN];
                SMR_OFF_REFERENCE_CONTROL:
                begin
                    st_d.high_ref_enable =
                        req.wdata[SMR_BIT_HIGH_REF_EN];
                    st_d.low_ref_enable =
                        req.wdata[SMR_BIT_LOW_REF_EN];
                    st_d.high_ref_pin_out = req.wdata[SMR_BIT_HIGH_PIN_OUT];
                    st_d.low_ref_pin_out = req.wdata[SMR_BIT_LOW_PIN_OUT];
                end
                SMR_OFF_SUPPLY_DROP_CONTROL:
                begin
                    st_d.detector_enable =
                        req.wdata[SMR_BIT_DET_EN];
                    st_d.trip_select = req.wdata[3:0];
                end
                SMR_OFF_MISC_CONTROL:
                    st_d.brownout_enable = req.wdata[SMR_BIT_BROWNOUT_EN];
                default:
                    st_d.rdata = 8'h00;
            endcase
        end
        // hardware set wins over any clear in the same cycle
        if (st_q.detector_enable && src_stable && below_trip)
            st_d.supply_drop_flag = 1'b1;
        // register reads, data valid the next cycle
        if (req.rd)
        begin
            case (req.addr)
                SMR_OFF_PERIPH_FLAGS_TWO:
                    st_d.rdata[SMR_BIT_DROP_FLAG] = st_q.supply_drop_flag;
                SMR_OFF_PERIPH_ENABLES_TWO:
                    st_d.rdata[SMR_BIT_DROP_IRQ_EN] =
                        st_q.supply_drop_irq_enable;
                SMR_OFF_REFERENCE_CONTROL:
                begin
                    st_d.rdata[SMR_BIT_HIGH_REF_EN] = st_q.high_ref_enable;
                    st_d.rdata[SMR_BIT_LOW_REF_EN] = st_q.low_ref_enable;
                    st_d.rdata[SMR_BIT_HIGH_PIN_OUT] = st_q.high_ref_pin_out;
                    st_d.rdata[SMR_BIT_LOW_PIN_OUT] = st_q.low_ref_pin_out;
                end
                SMR_OFF_SUPPLY_DROP_CONTROL:
                begin
                    st_d.rdata[SMR_BIT_REF_STABLE] = src_stable;
                    st_d.rdata[SMR_BIT_DET_EN] = st_q.detector_enable;
                    st_d.rdata[3:0] = st_q.trip_select;
                end
                SMR_OFF_MISC_CONTROL:
                    st_d.rdata[SMR_BIT_BROWNOUT_EN] = st_q.brownout_enable;
                default:
                    st_d.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------
    // state register
    // ----------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= '0;
            st_q.trip_select <= SMR_RST_REG[3:0];
        end
        else
            st_q <= st_d;
    end

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    assign reg_rdata = st_q.rdata;
    assign ref_source_on = src_powered;
    assign trip_select = st_q.trip_select;
    assign external_trip_input_sel =
        (st_q.trip_select == SMR_TRIP_EXTERNAL);
    assign detector_on = st_q.detector_enable;
    assign high_internal_ref_on = st_q.high_ref_enable;
    assign low_internal_ref_on = st_q.low_ref_enable;
    assign high_internal_ref_ready = high_amp_ready;
    assign low_internal_ref_ready = low_amp_ready;
    // pin routing only when its reference is on
    assign high_ref_pin_drive =
        st_q.high_ref_pin_out & st_q.high_ref_enable;
    assign low_ref_pin_drive =
        st_q.low_ref_pin_out & st_q.low_ref_enable;
    assign supply_drop_irq =
        st_q.supply_drop_flag & st_q.supply_drop_irq_enable;
    assign wake_request = supply_drop_irq;
endmodule

// *** logic/smr_pkg.sv ***
package smr_pkg;
    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [7:0] SMR_OFF_PERIPH_FLAGS_TWO = 8'h0d;
    localparam logic [7:0] SMR_OFF_PERIPH_ENABLES_TWO = 8'h8d;
    localparam logic [7:0] SMR_OFF_REFERENCE_CONTROL = 8'h9b;
    localparam logic [7:0] SMR_OFF_SUPPLY_DROP_CONTROL = 8'h9c;
    localparam logic [7:0] SMR_OFF_MISC_CONTROL = 8'hf0;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int SMR_BIT_DROP_FLAG = 7;
    localparam int SMR_BIT_DROP_IRQ_EN = 7;
    localparam int SMR_BIT_HIGH_REF_EN = 7;
    localparam int SMR_BIT_LOW_REF_EN = 6;
    localparam int SMR_BIT_HIGH_PIN_OUT = 5;
    localparam int SMR_BIT_LOW_PIN_OUT = 4;
    localparam int SMR_BIT_REF_STABLE = 5;
    localparam int SMR_BIT_DET_EN = 4;
    localparam int SMR_BIT_BROWNOUT_EN = 0;
    localparam logic [3:0] SMR_TRIP_EXTERNAL = 4'hf;
    // -------------------------------------------------------------
    // reset values and timing
    // -------------------------------------------------------------
    localparam logic [7:0] SMR_RST_REG = 8'h00;
    localparam int SMR_CLK_MHZ = 250;
    localparam int SMR_REF_START_US = 10;
    localparam int SMR_REF_START_CYC = SMR_REF_START_US * SMR_CLK_MHZ;
    localparam int SMR_AMP_START_US = 10;
    localparam int SMR_AMP_START_CYC = SMR_AMP_START_US * SMR_CLK_MHZ;
    localparam int SMR_CNT_W = 16;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smr_bus_req_t;

    typedef enum logic [1:0] {
        SMR_REF_OFF = 2'b00,
        SMR_REF_STARTING = 2'b01,
        SMR_REF_STABLE = 2'b10
    } smr_ref_state_t;
endpackage

// *** logic/smr_settle_timer.sv ***
`timescale 1ns/1ps
module smr_settle_timer
    import smr_pkg::*;
#(
    parameter int CYCLES = SMR_AMP_START_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    output logic ready
);
    initial
    begin
        if (CYCLES < 1 || CYCLES >= (1 << SMR_CNT_W))
            $error("smr_settle_timer: CYCLES out of range");
    end

    typedef struct packed {
        logic [SMR_CNT_W-1:0] cnt;
        logic ready;
    } smr_tmr_st_t;

    localparam logic [SMR_CNT_W-1:0] LAST = SMR_CNT_W'(CYCLES - 1);

    smr_tmr_st_t st_q;
    smr_tmr_st_t st_d;

    // ----------------------------------------------------------
    // count while enabled, drop at once when disabled
    // ----------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        if (!enable)
        begin
            st_d.cnt = '0;
            st_d.ready = 1'b0;
        end
        else if (!st_q.ready)
        begin
            if (st_q.cnt == LAST)
                st_d.ready = 1'b1;
            else
                st_d.cnt = st_q.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // ready falls in the same cycle as its enable, never lingers
    assign ready = st_q.ready & enable;
endmodule

// *** logic/smr_ref_source.sv ***
`timescale 1ns/1ps
module smr_ref_source
    import smr_pkg::*;
#(
    parameter int START_CYCLES = SMR_REF_START_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic power_req,
    output logic powered,
    output logic stable
);
    initial
    begin
        if (START_CYCLES < 1 || START_CYCLES >= (1 << SMR_CNT_W))
            $error("smr_ref_source: START_CYCLES out of range");
    end

    typedef struct packed {
        smr_ref_state_t fsm;
        logic [SMR_CNT_W-1:0] cnt;
    } smr_src_st_t;

    localparam logic [SMR_CNT_W-1:0] LAST = SMR_CNT_W'(START_CYCLES - 1);

    smr_src_st_t st_q;
    smr_src_st_t st_d;

    // ----------------------------------------------------------
    // power up, settle, report stable; power down re-arms
    // ----------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        case (st_q.fsm)
            SMR_REF_OFF:
            begin
                st_d.cnt = '0;
                if (power_req)
                    st_d.fsm = SMR_REF_STARTING;
            end
            SMR_REF_STARTING:
            begin
                if (!power_req)
                    st_d.fsm = SMR_REF_OFF;
                else if (st_q.cnt == LAST)
                    st_d.fsm = SMR_REF_STABLE;
                else
                    st_d.cnt = st_q.cnt + 1'b1;
            end
            SMR_REF_STABLE:
            begin
                if (!power_req)
                    st_d.fsm = SMR_REF_OFF;
            end
            default:
                st_d.fsm = SMR_REF_OFF;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q.fsm <= SMR_REF_OFF;
            st_q.cnt <= '0;
        end
        else
            st_q <= st_d;
    end

    assign powered = (st_q.fsm != SMR_REF_OFF);
    assign stable = (st_q.fsm == SMR_REF_STABLE);
endmodule

// *** dv/smr_supply_monitor_chk.sv ***
`timescale 1ns/1ps
module smr_supply_monitor_chk
    import smr_pkg::*;
#(
    parameter int REF_START_CYCLES = 4,
    parameter int AMP_START_CYCLES = 4
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] trip_select,
    input wire logic external_trip_input_sel,
    input wire logic ref_source_on,
    input wire logic detector_on,
    input wire logic high_internal_ref_on,
    input wire logic low_internal_ref_on,
    input wire logic high_internal_ref_ready,
    input wire logic low_internal_ref_ready,
    input wire logic high_ref_pin_drive,
    input wire logic low_ref_pin_drive,
    input wire logic supply_drop_irq,
    input wire logic wake_request
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ---------------------------------------------------------
    // port relations
    // ---------------------------------------------------------
    high_pin_gate_a: assert property
        (high_ref_pin_drive |-> high_internal_ref_on)
        else $error("high pin driven while reference off");
    low_pin_gate_a: assert property
        (low_ref_pin_drive |-> low_internal_ref_on)
        else $error("low pin driven while reference off");
    ext_trip_sel_a: assert property
        (external_trip_input_sel == (trip_select == SMR_TRIP_EXTERNAL))
        else $error("external trip select mismatch");
    wake_follows_irq_a: assert property
        (wake_request == supply_drop_irq)
        else $error("wake request differs from interrupt");
    source_power_up_a: assert property
        ($rose(high_internal_ref_on) |-> ##1 ref_source_on)
        else $error("source not powered for high reference");
    high_ready_on_a: assert property
        (high_internal_ref_ready |-> high_internal_ref_on)
        else $error("high ready without enable");
    low_ready_on_a: assert property
        (low_internal_ref_ready |-> low_internal_ref_on)
        else $error("low ready without enable");
    high_ready_wait_a: assert property
        ($rose(high_internal_ref_on) |-> !high_internal_ref_ready [*3])
        else $error("high ready without start-up time");
    det_enable_wr_a: assert property
        (reg_wr && reg_addr == SMR_OFF_SUPPLY_DROP_CONTROL
            |=> detector_on == $past(reg_wdata[SMR_BIT_DET_EN]))
        else $error("detector enable not taken from write");
    trip_field_wr_a: assert property
        (reg_wr && reg_addr == SMR_OFF_SUPPLY_DROP_CONTROL
            |=> trip_select == $past(reg_wdata[3:0]))
        else $error("trip select not taken from write");
    rdata_idle_a: assert property
        (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    // main scenarios
    cover property (supply_drop_irq);
    cover property (external_trip_input_sel && detector_on);
    cover property (high_internal_ref_ready && low_internal_ref_ready);
endmodule

bind smr_supply_monitor smr_supply_monitor_chk #(
    .REF_START_CYCLES(REF_START_CYCLES),
    .AMP_START_CYCLES(AMP_START_CYCLES)
) u_smr_supply_monitor_chk (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trip_select(trip_select),
    .external_trip_input_sel(external_trip_input_sel),
    .ref_source_on(ref_source_on), .detector_on(detector_on),
    .high_internal_ref_on(high_internal_ref_on),
    .low_internal_ref_on(low_internal_ref_on),
    .high_internal_ref_ready(high_internal_ref_ready),
    .low_internal_ref_ready(low_internal_ref_ready),
    .high_ref_pin_drive(high_ref_pin_drive),
    .low_ref_pin_drive(low_ref_pin_drive),
    .supply_drop_irq(supply_drop_irq), .wake_request(wake_request)
);

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import smr_pkg::*;
    localparam int SETTLE = 4 + 4 + 4;
    logic sys_clk, rst, reg_wr, reg_rd, bi, be, strap;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] trip;
    logic src, ext, det, hon, lon, hrdy, lrdy, hpin, lpin, irq, wake;
    int fail_count, checks;

    smr_supply_monitor #(.REF_START_CYCLES(4), .AMP_START_CYCLES(4))
    u_smr_supply_monitor (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .supply_below_internal(bi),
        .supply_below_external(be), .brownout_strap(strap),
        .ref_source_on(src), .trip_select(trip),
        .external_trip_input_sel(ext), .detector_on(det),
        .high_internal_ref_on(hon), .low_internal_ref_on(lon),
        .high_internal_ref_ready(hrdy), .low_internal_ref_ready(lrdy),
        .high_ref_pin_drive(hpin), .low_ref_pin_drive(lpin),
        .supply_drop_irq(irq), .wake_request(wake)
    );

    // ---------------------------------------------------------
    // helpers
    // ---------------------------------------------------------
    task end_of_test;
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string w);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task chb(input logic seen, input logic exp, input string w);
        chk({7'h0, seen}, {7'h0, exp}, w);
    endtask
    // one-cycle write strobe
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read data sampled in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e, "reg_rdata");
    endtask
    task idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // clock and watchdog
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        end_of_test;
    end

    // ---------------------------------------------------------
    // tests
    // ---------------------------------------------------------
    initial
    begin
        {rst, reg_wr, reg_rd, bi, be, strap} = 6'b100000;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fail_count = 0;
        checks = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h0d, 8'h00);
        rd(8'h8d, 8'h00);
        rd(8'h9b, 8'h00);
        rd(8'h9c, 8'h00);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        chb(src, 1'b0, "ref_source_on");
        // detector started with the supply already low
        bi <= 1'b1;
        wr(8'h9c, 8'h03);
        wr(8'h9c, 8'h13);
        chb(det, 1'b1, "detector_on");
        rd(8'h0d, 8'h00);
        idle(SETTLE);
        rd(8'h9c, 8'h33);
        rd(8'h0d, 8'h80);
        chb(irq, 1'b0, "supply_drop_irq");
        wr(8'h8d, 8'h80);
        chb(irq, 1'b1, "supply_drop_irq");
        chb(wake, 1'b1, "wake_request");
        wr(8'h0d, 8'h00);
        rd(8'h0d, 8'h80);
        wr(8'h8d, 8'h00);
        chb(irq, 1'b0, "supply_drop_irq");
        bi <= 1'b0;
        wr(8'h0d, 8'h00);
        rd(8'h0d, 8'h00);
        // external trip input
        be <= 1'b1;
        wr(8'h9c, 8'h1f);
        chb(ext, 1'b1, "external_trip_input_sel");
        idle(2);
        rd(8'h0d, 8'h80);
        {bi, be} <= 2'b10;
        wr(8'h0d, 8'h00);
        rd(8'h0d, 8'h00);
        bi <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h9c, 8'h10 | i[7:0]);
            chk({4'h0, trip}, i[7:0], "trip_select");
            chb(ext, i == 15, "external_trip_input_sel");
        end
        // all consumers off powers the source down
        wr(8'h9c, 8'h00);
        chb(det, 1'b0, "detector_on");
        idle(3);
        chb(src, 1'b0, "ref_source_on");
        rd(8'h9c, 8'h00);
        // internal references and pin routing
        wr(8'h9b, 8'h30);
        idle(3);
        chk({6'h0, hpin, lpin}, 8'h00, "pin_drive");
        chb(src, 1'b0, "ref_source_on");
        wr(8'h9b, 8'hb0);
        chb(hon, 1'b1, "high_internal_ref_on");
        chk({6'h0, hpin, lpin}, 8'h02, "pin_drive");
        idle(SETTLE);
        chb(hrdy, 1'b1, "high_internal_ref_ready");
        chb(lrdy, 1'b0, "low_internal_ref_ready");
        rd(8'h9c, 8'h20);
        wr(8'h9b, 8'hf0);
        chb(lon, 1'b1, "low_internal_ref_on");
        idle(SETTLE);
        chb(lrdy, 1'b1, "low_internal_ref_ready");
        chk({6'h0, hpin, lpin}, 8'h03, "pin_drive");
        rd(8'h9b, 8'hf0);
        wr(8'h9b, 8'h00);
        idle(3);
        chb(src, 1'b0, "ref_source_on");
        // brownout enable keeps the source on
        wr(8'hf0, 8'h01);
        idle(3);
        chb(src, 1'b1, "ref_source_on");
        rd(8'hf0, 8'h01);
        // mid-run reset with the brownout strap set
        strap <= 1'b1;
        rst <= 1'b1;
        idle(2);
        chb(src, 1'b0, "ref_source_on");
        rst <= 1'b0;
        idle(3);
        chb(src, 1'b1, "ref_source_on");
        rd(8'hf0, 8'h01);
        end_of_test;
    end
endmodule
